// file: rtl/reset_entry_and_boot_vector.sv
// reset sequencer: gathers reset sources, holds core and peripherals, picks boot vector
// assumes sources are asynchronous levels and the signature byte is stable once valid
`timescale 1ns/1ps
// Function
// R1: core is halted while any reset state lasts.
// R2: module registers take reset values; power-on-only bits reset only on power-on.
// R3: port latches forced to one with open-drain drivers during reset.
// R4: interrupts and timers held disabled while reset is active.
// R5: data RAM is never cleared by any reset.
// R6: weak pull-ups enabled during and after reset.
// R7: external reset pin driven low for power-on and supply resets only.
// R8: on exit program counter cleared and internal oscillator selected.
// R9: watchdog enabled and counting on exit without software.
// R10: fetch starts at 0x0000 unless a bootloader is detected.
// R11: reset entered on any of nine listed sources.
// R12: signature 0xA5 alone marks bootloader present.
// R13: bootloader present means start at bootloader vector after every reset.
// R14: no bootloader means start at 0x0000 after every reset.
// R15: clock after reset is low power oscillator divided by 8.
// R16: watchdog reset leaves the external reset pin alone.
// R17: internal reset held, synchronised, until all sources released.
module reset_entry_and_boot_vector (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire rst_seq_pkg::src_vec_t   reset_src,
  input  wire logic [7:0]              boot_signature,
  output      rst_seq_pkg::core_ctl_t  core_ctl,
  output      rst_seq_pkg::periph_ctl_t periph_ctl,
  output      logic                    ram_clear,
  output      logic                    external_reset_pin_o,
  output      logic                    external_reset_pin_oe,
  output      logic                    in_reset
);

  typedef struct packed {
    rst_seq_pkg::seq_state_t  state;
    logic                     pin_drive;
    rst_seq_pkg::core_ctl_t   core;
    rst_seq_pkg::periph_ctl_t periph;
  } seq_t;

  seq_t                  st_ff;
  seq_t                  nxt_st;
  rst_seq_pkg::src_vec_t src_sync;
  rst_seq_pkg::src_vec_t drive_mask;
  logic                  any_src;
  logic                  drive_src;
  logic                  por_src;
  logic                  boot_found;

  // core controls while the core is stopped: nothing fetches, no watchdog pulse
  function automatic rst_seq_pkg::core_ctl_t core_held(input rst_seq_pkg::core_ctl_t cur);
    rst_seq_pkg::core_ctl_t c;
    c               = cur;
    c.core_halt     = 1'b1;  // R1
    c.core_fetch_en = 1'b0;  // R1
    c.wdt_start     = 1'b0;
    return c;
  endfunction : core_held

  // core controls at the first run cycle
  function automatic rst_seq_pkg::core_ctl_t core_run(input logic boot);
    rst_seq_pkg::core_ctl_t c;
    c.core_halt       = 1'b0;
    c.core_fetch_en   = 1'b1;
    c.program_counter = boot ? rst_seq_pkg::BOOT_VECTOR :  // R13
                               rst_seq_pkg::RESET_VECTOR;  // R8 R10 R14
    c.clk_src         = rst_seq_pkg::CLK_SRC_LPOSC;  // R8 R15
    c.clk_div         = rst_seq_pkg::CLK_DIV_RESET;  // R15
    c.wdt_start       = 1'b1;  // R9
    return c;
  endfunction : core_run

  // peripheral controls while reset lasts; por_only sets the power-on-only bits
  function automatic rst_seq_pkg::periph_ctl_t periph_held(input logic por_only);
    rst_seq_pkg::periph_ctl_t p;
    p.reg_reset       = 1'b1;  // R2
    p.por_reg_reset   = por_only;  // R2
    p.irq_disable     = 1'b1;  // R4
    p.timer_disable   = 1'b1;  // R4
    p.latch_force_one = '1;  // R3
    p.open_drain      = 1'b1;  // R3
    p.weak_pullup_en  = 1'b1;  // R6
    return p;
  endfunction : periph_held

  // peripheral controls in run: everything released, pull-ups stay on
  function automatic rst_seq_pkg::periph_ctl_t periph_run();
    rst_seq_pkg::periph_ctl_t p;
    p.reg_reset       = 1'b0;
    p.por_reg_reset   = 1'b0;
    p.irq_disable     = 1'b0;
    p.timer_disable   = 1'b0;
    p.latch_force_one = '0;
    p.open_drain      = 1'b0;
    p.weak_pullup_en  = 1'b1;  // R6
    return p;
  endfunction : periph_run

  rst_src_sync u_sync (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .src_async (reset_src),
    .src_sync  (src_sync)
  );

  // only power-on and supply resets may drive the pin; watchdog and the rest stay off it
  for (genvar g = 0; g < rst_seq_pkg::SRC_COUNT; g++) begin : g_drive_mask
    if (g == rst_seq_pkg::SRC_POR || g == rst_seq_pkg::SRC_SUPPLY) begin : g_on
      assign drive_mask[g] = 1'b1;  // R7
    end else begin : g_off
      assign drive_mask[g] = 1'b0;  // R16
    end
  end

  assign any_src    = |src_sync;  // R11
  assign por_src    = src_sync[rst_seq_pkg::SRC_POR];
  assign drive_src  = |(src_sync & drive_mask);  // R7 R16
  assign boot_found = (boot_signature == rst_seq_pkg::BOOT_SIGNATURE);  // R12

  always_comb begin
    nxt_st                = st_ff;
    nxt_st.core.wdt_start = 1'b0;
    case (st_ff.state)
      rst_seq_pkg::ST_HOLD: begin
        nxt_st.core      = core_held(st_ff.core);  // R1
        nxt_st.periph    = periph_held(st_ff.periph.por_reg_reset | por_src);  // R2 R3 R4
        // once a power reset drives the pin it stays driven until the core runs
        nxt_st.pin_drive = st_ff.pin_drive | drive_src;  // R7
        if (!any_src) begin
          nxt_st.state = rst_seq_pkg::ST_RELEASE;  // R17
        end
      end
      rst_seq_pkg::ST_RELEASE: begin
        if (any_src) begin
          // a source back in the release cycle cancels the run
          nxt_st.state = rst_seq_pkg::ST_HOLD;  // R17
        end else begin
          nxt_st.state     = rst_seq_pkg::ST_RUN;
          nxt_st.core      = core_run(boot_found);  // R8 R9 R10 R13 R14 R15
          nxt_st.periph    = periph_run();  // R6
          nxt_st.pin_drive = 1'b0;  // R7
        end
      end
      rst_seq_pkg::ST_RUN: begin
        if (any_src) begin
          nxt_st.state     = rst_seq_pkg::ST_HOLD;  // R11
          nxt_st.core      = core_held(st_ff.core);  // R1
          nxt_st.periph    = periph_held(por_src);  // R2 R3 R4
          // a watchdog or other reset leaves the pin released
          nxt_st.pin_drive = drive_src;  // R7 R16
        end
      end
      default: begin
        nxt_st.state = rst_seq_pkg::ST_HOLD;
      end
    endcase
    nxt_st.periph.weak_pullup_en = 1'b1;  // R6
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff.state        <= rst_seq_pkg::ST_HOLD;
      st_ff.pin_drive    <= 1'b1;
      st_ff.core         <= '{core_halt: 1'b1, core_fetch_en: 1'b0,
                              program_counter: rst_seq_pkg::RESET_VECTOR,
                              clk_src: rst_seq_pkg::CLK_SRC_LPOSC,
                              clk_div: rst_seq_pkg::CLK_DIV_RESET, wdt_start: 1'b0};
      st_ff.periph       <= '{reg_reset: 1'b1, por_reg_reset: 1'b1, irq_disable: 1'b1,
                              timer_disable: 1'b1, latch_force_one: '1,
                              open_drain: 1'b1, weak_pullup_en: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign core_ctl              = st_ff.core;
  assign periph_ctl            = st_ff.periph;
  assign ram_clear             = 1'b0;  // R5
  assign external_reset_pin_o  = 1'b0;
  assign external_reset_pin_oe = st_ff.pin_drive;  // R7
  assign in_reset              = (st_ff.state != rst_seq_pkg::ST_RUN);

endmodule : reset_entry_and_boot_vector

// file: rtl/rst_seq_pkg.sv
// package for the reset entry and boot vector block: source indices, vectors, widths
// assumes one system clock domain and no software-visible registers
package rst_seq_pkg;

  localparam int unsigned SRC_COUNT  = 9;
  // source bit positions
  localparam int unsigned SRC_POR    = 0;
  localparam int unsigned SRC_PIN    = 1;
  localparam int unsigned SRC_CMP    = 2;
  localparam int unsigned SRC_SW     = 3;
  localparam int unsigned SRC_SUPPLY = 4;
  localparam int unsigned SRC_WDT    = 5;
  localparam int unsigned SRC_MCD    = 6;
  localparam int unsigned SRC_FLASH  = 7;
  localparam int unsigned SRC_RTC    = 8;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned PORT_W = 17;

  localparam logic [ADDR_W-1:0] RESET_VECTOR   = 16'h0000;
  // bootloader entry address; plain default, set per flash layout
  localparam logic [ADDR_W-1:0] BOOT_VECTOR    = 16'h1e00;
  localparam logic [7:0]        BOOT_SIGNATURE = 8'ha5;

  localparam logic [2:0] CLK_DIV_RESET = 3'h3;  // divide by 8
  localparam logic [1:0] CLK_SRC_LPOSC = 2'h0;  // low power internal oscillator

  typedef logic [SRC_COUNT-1:0] src_vec_t;

  typedef struct packed {
    logic              core_halt;
    logic              core_fetch_en;
    logic [ADDR_W-1:0] program_counter;
    logic [1:0]        clk_src;
    logic [2:0]        clk_div;
    logic              wdt_start;
  } core_ctl_t;

  typedef struct packed {
    logic              reg_reset;
    logic              por_reg_reset;
    logic              irq_disable;
    logic              timer_disable;
    logic [PORT_W-1:0] latch_force_one;
    logic              open_drain;
    logic              weak_pullup_en;
  } periph_ctl_t;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_RELEASE,
    ST_RUN
  } seq_state_t;

endpackage : rst_seq_pkg

// file: rtl/rst_src_sync.sv
// two-stage synchroniser for every reset source into sys_clk
// assumes sources are asynchronous levels, high while asserting
`timescale 1ns/1ps
module rst_src_sync (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire rst_seq_pkg::src_vec_t src_async,
  output      rst_seq_pkg::src_vec_t src_sync
);

  typedef struct packed {
    rst_seq_pkg::src_vec_t meta;
    rst_seq_pkg::src_vec_t sync;
  } sync_state_t;

  sync_state_t st_ff;
  sync_state_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.meta = src_async;
    nxt_st.sync = st_ff.meta;
  end

  // sources read as asserted while rst is high
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign src_sync = st_ff.sync;

endmodule : rst_src_sync

// file: verif/rst_seq_monitor.sv
// assertions on the ports of the reset sequencer
// assumes one clock domain, rst asynchronous and active high
`timescale 1ns/1ps
module rst_seq_monitor (
  input wire logic                     sys_clk,
  input wire logic                     rst,
  input wire rst_seq_pkg::src_vec_t    reset_src,
  input wire logic [7:0]               boot_signature,
  input wire rst_seq_pkg::core_ctl_t   core_ctl,
  input wire rst_seq_pkg::periph_ctl_t periph_ctl,
  input wire logic                     ram_clear,
  input wire logic                     external_reset_pin_o,
  input wire logic                     external_reset_pin_oe,
  input wire logic                     in_reset
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic pwr;
  logic boot_hit;
  assign pwr      = reset_src[rst_seq_pkg::SRC_POR] | reset_src[rst_seq_pkg::SRC_SUPPLY];
  assign boot_hit = (boot_signature == rst_seq_pkg::BOOT_SIGNATURE);
  sequence seq_release;
    in_reset ##1 !in_reset;
  endsequence
  sequence seq_quiet;
    (!external_reset_pin_oe && !pwr)[*4];
  endsequence
  AST_HALT: assert property (in_reset |-> core_ctl.core_halt && !core_ctl.core_fetch_en)
    else $error("core not held");
  AST_RUN: assert property (!in_reset |-> !core_ctl.core_halt && core_ctl.core_fetch_en)
    else $error("core held in run");
  AST_DIS: assert property (in_reset |-> periph_ctl.irq_disable
    && periph_ctl.timer_disable && periph_ctl.reg_reset) else $error("disables low in reset");
  AST_LATCH: assert property (in_reset |-> &periph_ctl.latch_force_one
    && periph_ctl.open_drain) else $error("latches not forced");
  AST_PULL: assert property (periph_ctl.weak_pullup_en && !ram_clear
    && !external_reset_pin_o) else $error("pullup or ram clear wrong");
  AST_ENTRY: assert property (|reset_src |-> ##[1:4] in_reset)
    else $error("source did not enter reset");
  AST_PINPOR: assert property (pwr |-> ##[1:4] external_reset_pin_oe)
    else $error("pin not driven");
  AST_WDTPIN: assert property (seq_quiet |=> !external_reset_pin_oe)
    else $error("pin driven without power reset");
  AST_WDTONE: assert property (core_ctl.wdt_start |=> !core_ctl.wdt_start)
    else $error("watchdog start longer than one cycle");
  AST_BOOT: assert property (seq_release |-> core_ctl.wdt_start
    && !external_reset_pin_oe && core_ctl.clk_src == rst_seq_pkg::CLK_SRC_LPOSC
    && core_ctl.clk_div == rst_seq_pkg::CLK_DIV_RESET
    && core_ctl.program_counter == ($past(boot_hit) ? rst_seq_pkg::BOOT_VECTOR
    : rst_seq_pkg::RESET_VECTOR)) else $error("bad run entry");
endmodule : rst_seq_monitor
bind reset_entry_and_boot_vector rst_seq_monitor u_mon (.sys_clk(sys_clk), .rst(rst),
  .reset_src(reset_src), .boot_signature(boot_signature), .core_ctl(core_ctl),
  .periph_ctl(periph_ctl), .ram_clear(ram_clear), .external_reset_pin_o(external_reset_pin_o),
  .external_reset_pin_oe(external_reset_pin_oe), .in_reset(in_reset));

// file: verif/src_model.sv
// model of the reset sources and the flash signature byte
// assumes the bench sets wanted levels; outputs move just after sys_clk rises
`timescale 1ns/1ps
module src_model (
  input  wire logic                  sys_clk,
  input  wire rst_seq_pkg::src_vec_t want,
  input  wire logic [7:0]            sig_want,
  output rst_seq_pkg::src_vec_t      reset_src,
  output logic [7:0]                 boot_signature
);
  always_ff @(posedge sys_clk) begin
    reset_src      <= want;
    boot_signature <= sig_want;
  end
endmodule : src_model

// file: verif/tb_top.sv
// self-checking bench for the reset sequencer driven through a source model
// assumes a 200 MHz sys_clk and the package constants
`timescale 1ns/1ps
module tb_top;
  logic                     sys_clk = 1'b0;
  logic                     rst = 1'b1;
  rst_seq_pkg::src_vec_t    want = '0;
  logic [7:0]               sig_want = 8'ha5;
  rst_seq_pkg::src_vec_t    reset_src;
  logic [7:0]               boot_signature;
  rst_seq_pkg::core_ctl_t   core_ctl;
  rst_seq_pkg::periph_ctl_t periph_ctl;
  logic                     ram_clear, pin_o, pin_oe, in_reset;
  int                       err_total = 0;
  int                       checks_done = 0;
  int                       cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  src_model PARTNER (.sys_clk(sys_clk), .want(want), .sig_want(sig_want),
    .reset_src(reset_src), .boot_signature(boot_signature));
  reset_entry_and_boot_vector DUT (.sys_clk(sys_clk), .rst(rst), .reset_src(reset_src),
    .boot_signature(boot_signature), .core_ctl(core_ctl), .periph_ctl(periph_ctl),
    .ram_clear(ram_clear), .external_reset_pin_o(pin_o), .external_reset_pin_oe(pin_oe),
    .in_reset(in_reset));
  function automatic logic [15:0] exp_pc(input logic [7:0] s);
    return (s == rst_seq_pkg::BOOT_SIGNATURE) ? rst_seq_pkg::BOOT_VECTOR
                                              : rst_seq_pkg::RESET_VECTOR;
  endfunction : exp_pc
  function automatic logic exp_pin(input rst_seq_pkg::src_vec_t v);
    return v[rst_seq_pkg::SRC_POR] | v[rst_seq_pkg::SRC_SUPPLY];
  endfunction : exp_pin
  task automatic complete_run;
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic hold_chk(input rst_seq_pkg::src_vec_t v);
    logic [15:0] dis;
    dis = {13'h0, periph_ctl.irq_disable, periph_ctl.timer_disable, periph_ctl.reg_reset};
    chk("halt", {14'h0, core_ctl.core_halt, core_ctl.core_fetch_en}, 16'h2);
    chk("dis", dis, 16'h7);
    chk("latch", {14'h0, &periph_ctl.latch_force_one, periph_ctl.open_drain}, 16'h3);
    chk("pull", {14'h0, periph_ctl.weak_pullup_en, ram_clear}, 16'h2);
    chk("pin", {14'h0, pin_o, pin_oe}, {15'h0, exp_pin(v)});
    chk("por", {15'h0, periph_ctl.por_reg_reset}, {15'h0, v[rst_seq_pkg::SRC_POR]});
  endtask : hold_chk
  task automatic wait_run(input logic [7:0] s);
    int          n;
    logic [15:0] rel;
    logic [15:0] clk_exp;
    n = 0;
    clk_exp = {11'h0, rst_seq_pkg::CLK_SRC_LPOSC, rst_seq_pkg::CLK_DIV_RESET};
    while (in_reset !== 1'b0 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    rel = {11'h0, periph_ctl.irq_disable, periph_ctl.timer_disable, periph_ctl.reg_reset,
           periph_ctl.open_drain, |periph_ctl.latch_force_one};
    chk("run", {14'h0, in_reset, core_ctl.core_fetch_en}, 16'h1);
    chk("pc", core_ctl.program_counter, exp_pc(s));
    chk("clk", {11'h0, core_ctl.clk_src, core_ctl.clk_div}, clk_exp);
    chk("wdt", {14'h0, core_ctl.wdt_start, pin_oe}, 16'h2);
    chk("pull", {15'h0, periph_ctl.weak_pullup_en}, 16'h1);
    chk("rel", rel, 16'h0);
  endtask : wait_run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    rst_seq_pkg::src_vec_t v;
    logic [7:0] s;
    void'($urandom(32'h8406));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    wait_run(8'ha5);
    for (int i = 0; i < 24; i++) begin
      v = (i < 9) ? rst_seq_pkg::src_vec_t'(1 << i) : rst_seq_pkg::src_vec_t'($urandom);
      if (v == '0) v = 9'h020;
      case (i % 4)
        0: s = 8'ha5;
        1: s = 8'ha4;
        2: s = 8'h25;
        default: s = 8'($urandom);
      endcase
      @(posedge sys_clk);
      want <= v;
      sig_want <= s;
      repeat (6 + $urandom % 4) @(posedge sys_clk);
      #1;
      hold_chk(v);
      @(posedge sys_clk);
      want <= '0;
      wait_run(s);
    end
    // mid-run reset acts as a power-on reset
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    #1;
    hold_chk(rst_seq_pkg::src_vec_t'(1));
    @(posedge sys_clk);
    rst <= 1'b0;
    wait_run(s);
    complete_run();
  end
endmodule : tb_top
